// [hw/sync_regs_params.svh]
`ifndef SYNC_REGS_PARAMS_SVH
`define SYNC_REGS_PARAMS_SVH
// Register indices; the byte address of each register is four times its index.
`define IDX_INPUT_PIN_CONFIG   8'h3a
`define IDX_LOCK_SOURCE_SELECT 8'h3b
`define IDX_LOCK_DELAY         8'h3c
`define IDX_MOD_WAIT_HIGH      8'h45
`define IDX_MOD_WAIT_LOW       8'h46
`define IDX_SYSREF_CONTROL     8'h47
`define IDX_SYSREF_DIVIDER     8'h48
`define IDX_SYSREF_WEIGHTS_A   8'h49
`define IDX_SYSREF_WEIGHTS_B   8'h4a
`define IDX_AUX_CONTROL        8'h50
`define IDX_IRQ_STATUS         8'h51
`define IDX_IRQ_MASK           8'h52
`define IDX_BLOCK_STATE        8'h53
// Reset values.
`define RST_INPUT_PIN_CONFIG   16'h8001
`define RST_LOCK_SOURCE_SELECT 16'h0001
`define RST_LOCK_DELAY         16'h03e8
`define RST_MOD_WAIT_HIGH      16'h0000
`define RST_MOD_WAIT_LOW       16'hc350
`define RST_SYSREF_CONTROL     16'h0081
`define RST_SYSREF_DIVIDER     16'h0000
`define RST_SYSREF_WEIGHTS_A   16'h003f
`define RST_SYSREF_WEIGHTS_B   16'h0000
// Writable bits; the others hold their reset value.
`define WM_INPUT_PIN_CONFIG    16'hfe00
`define WM_LOCK_SOURCE_SELECT  16'h0001
`define WM_SYSREF_CONTROL      16'h00fc
`define WM_SYSREF_DIVIDER      16'h07ff
`define WM_SYSREF_WEIGHTS_A    16'h0fff
`define WM_FULL                16'hffff
// Field positions.
`define F_PIN_DISREGARD        15
`define F_HIGH_HYST            14
`define F_BIAS_HI              13
`define F_BIAS_LO              12
`define F_FMT_HI               11
`define F_FMT_LO               9
`define F_LOCK_SOURCE          0
`define F_PRE_HI               7
`define F_PRE_LO               5
`define F_BURST_MODE           4
`define F_SYSREF_ENABLE        3
`define F_REPEATER             2
`define F_DIV_HI               10
`define F_BURST_CNT_HI         15
`define F_BURST_CNT_LO         12
`define F_AUX_PHASE_SYNC       0
`define F_AUX_FRACTIONAL       1
`define IRQ_LOCK               0
`define IRQ_MOD_WAIT_DONE      1
`define IRQ_BURST_DONE         2
`define IRQ_BITS               3
// Phase-detector clock period in ns; one lock delay step is one such period.
`define PD_PERIOD_NS           20
`define REF_PERIOD_NS          20
`define PD_CYCLES              (`PD_PERIOD_NS / `REF_PERIOD_NS)
`endif

// [hw/sync_regs_pkg.sv]
package sync_regs_pkg;
  typedef enum logic [1:0] {LK_WAIT, LK_COUNT, LK_LOCKED} lock_state_e;
  typedef enum logic [1:0] {SR_IDLE, SR_MASTER, SR_BURST, SR_REPEAT} sysref_state_e;
  typedef logic [3:0] slot_t;
endpackage

// [hw/sync_sysref_lock_control_regs.sv]
// Summary of operation
// [R01] Disregard bit set ignores both input pins; clear uses them under phase sync.
// [R02] High hysteresis bit enables high hysteresis for LVDS inputs.
// [R03] Bias field: 0 quarter, 1 full, 2 half input; 3 invalid.
// [R04] Host should choose full-input bias to use the whole swing.
// [R05] Format field picks CMOS or LVDS per pin; codes 4 to 7 invalid.
// [R06] Lock source: calibration only, or calibration with tuning-voltage monitor.
// [R07] Lock detect rises the delay count of cycles after calibration; reset 1000.
// [R08] Zero delay raises lock detect at once after calibration succeeds.
// [R09] Fractional phase sync delays divider release after modulator reset; reset 50000.
// [R10] Host sets modulator wait longer than loop lock time.
// [R11] Host may zero modulator wait outside fractional phase sync.
// [R12] Prescaler codes 1, 2, 4 divide by 1, 2, 4; others invalid.
// [R13] Burst mode bit gives limited pulse bursts, master mode only.
// [R14] Repeater select: 0 master generates internally, 1 repeats request.
// [R15] Divider divides by four plus twice the code.
// [R16] Host keeps two weights zero, other two summing to 63.
// [R17] Each burst emits the burst count number of pulses.
// [R18] Host sets enable when routing sysref to output B.
// [R19] Enable clear gives no sysref activity at all.
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "sync_regs_params.svh"
module sync_sysref_lock_control_regs
  import sync_regs_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        syncPin,
  input  wire logic        sysrefRequestPin,
  input  wire logic        calibrationOk,
  input  wire logic        vtuneOk,
  input  wire logic        modulatorReset,
  output logic             syncActive,
  output logic             sysrefRequestActive,
  output logic             highHysteresis,
  output logic [1:0]       biasLevel,
  output logic             syncPinLvds,
  output logic             requestPinLvds,
  output logic             pinConfigInvalid,
  output logic             lockDetect,
  output logic             dividerRelease,
  output logic             sysrefOut,
  output logic             irq
);
  logic [15:0] regs [0:8];
  logic [`IRQ_BITS-1:0] irqStatus;
  logic [`IRQ_BITS-1:0] irqMask;
  logic [1:0]  auxControl;
  logic [1:0]  syncMeta;
  logic [1:0]  reqMeta;
  logic        reqPrev;
  logic        awHeld;
  logic        wHeld;
  logic [11:0] awAddr;
  logic [31:0] wData;
  logic [3:0]  wStrb;
  lock_state_e lockState;
  logic [15:0] lockCount;
  logic [31:0] modCount;
  sysref_state_e srState;
  logic [13:0] srCount;
  logic [3:0]  pulseCount;

  // Maps a byte address to a slot: 0..8 documented, 9..12 auxiliary, 15 unmapped.
  function automatic slot_t slotOf(input logic [11:0] addr);
    logic [7:0] idx;
    idx = addr[9:2];
    slotOf = 4'hf;
    if (addr[1:0] == 2'h0 && addr[11:10] == 2'h0)
    begin
      unique case (idx)
        `IDX_INPUT_PIN_CONFIG:   slotOf = 4'h0;
        `IDX_LOCK_SOURCE_SELECT: slotOf = 4'h1;
        `IDX_LOCK_DELAY:         slotOf = 4'h2;
        `IDX_MOD_WAIT_HIGH:      slotOf = 4'h3;
        `IDX_MOD_WAIT_LOW:       slotOf = 4'h4;
        `IDX_SYSREF_CONTROL:     slotOf = 4'h5;
        `IDX_SYSREF_DIVIDER:     slotOf = 4'h6;
        `IDX_SYSREF_WEIGHTS_A:   slotOf = 4'h7;
        `IDX_SYSREF_WEIGHTS_B:   slotOf = 4'h8;
        `IDX_AUX_CONTROL:        slotOf = 4'h9;
        `IDX_IRQ_STATUS:         slotOf = 4'ha;
        `IDX_IRQ_MASK:           slotOf = 4'hb;
        `IDX_BLOCK_STATE:        slotOf = 4'hc;
        default:                 slotOf = 4'hf;
      endcase
    end
  endfunction

  localparam logic [15:0] RESETS [0:8] = '{`RST_INPUT_PIN_CONFIG, `RST_LOCK_SOURCE_SELECT,
    `RST_LOCK_DELAY, `RST_MOD_WAIT_HIGH, `RST_MOD_WAIT_LOW, `RST_SYSREF_CONTROL,
    `RST_SYSREF_DIVIDER, `RST_SYSREF_WEIGHTS_A, `RST_SYSREF_WEIGHTS_B};
  localparam logic [15:0] MASKS [0:8] = '{`WM_INPUT_PIN_CONFIG, `WM_LOCK_SOURCE_SELECT,
    `WM_FULL, `WM_FULL, `WM_FULL, `WM_SYSREF_CONTROL, `WM_SYSREF_DIVIDER,
    `WM_SYSREF_WEIGHTS_A, `WM_FULL};

  // Write path: address and data are taken in either order, then one response.
  wire        doWrite   = awHeld && wHeld && !s_axi_bvalid;
  wire slot_t wSlot     = slotOf(awAddr);
  wire [15:0] byteMask  = {{8{wStrb[1]}}, {8{wStrb[0]}}};
  wire slot_t rSlot     = slotOf(s_axi_araddr);
  wire        takeRead  = s_axi_arvalid && s_axi_arready;

  // Ready flags are registered so that every bus output leaves a flip-flop.
  assign awHeld = !s_axi_awready;
  assign wHeld  = !s_axi_wready;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      awAddr <= 12'h000;
      wData <= 32'h0000_0000;
      wStrb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end
    else
    begin
      if (s_axi_awvalid && !awHeld)
      begin
        s_axi_awready <= 1'b0;
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !wHeld)
      begin
        s_axi_wready <= 1'b0;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (doWrite)
      begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wSlot == 4'hf) ? 2'h2 : 2'h0;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 9; g++)
    begin : gen_regs
      wire [15:0] wm = MASKS[g] & byteMask;
      always_ff @(posedge ref_clk)
      begin
        if (rst)
          regs[g] <= RESETS[g];
        else if (doWrite && wSlot == slot_t'(g))
          regs[g] <= (wData[15:0] & wm) | (regs[g] & ~wm);
      end
    end
  endgenerate

  // Field views.
  wire        pinDisregard = regs[0][`F_PIN_DISREGARD];
  wire [2:0]  pinFormat    = regs[0][`F_FMT_HI:`F_FMT_LO];
  wire        lockSource   = regs[1][`F_LOCK_SOURCE];
  wire [15:0] lockDelay    = regs[2];
  wire [31:0] modWait      = {regs[3], regs[4]};
  wire [2:0]  prescaler    = regs[5][`F_PRE_HI:`F_PRE_LO];
  wire        burstMode    = regs[5][`F_BURST_MODE];
  wire        sysrefEnable = regs[5][`F_SYSREF_ENABLE];
  wire        repeaterSel  = regs[5][`F_REPEATER];
  wire [10:0] divCode      = regs[6][`F_DIV_HI:0];
  wire [3:0]  burstCount   = regs[8][`F_BURST_CNT_HI:`F_BURST_CNT_LO];
  wire        phaseSync    = auxControl[`F_AUX_PHASE_SYNC];
  wire        fractional   = auxControl[`F_AUX_FRACTIONAL];
  // [R06] lock source
  wire        lockOk       = calibrationOk && (!lockSource || vtuneOk);

  // Read path; unmapped addresses read zero with a slave error.
  wire [15:0] stateWord = {11'h000, srState != SR_IDLE, pinConfigInvalid,
    dividerRelease, lockDetect, sysrefOut};
  wire [15:0] readWord = (rSlot < 4'h9) ? regs[rSlot] :
                         (rSlot == 4'h9) ? {14'h0000, auxControl} :
                         (rSlot == 4'ha) ? {13'h0000, irqStatus} :
                         (rSlot == 4'hb) ? {13'h0000, irqMask} :
                         (rSlot == 4'hc) ? stateWord : 16'h0000;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end
    else if (takeRead)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_arready <= 1'b0;
      s_axi_rdata <= {16'h0000, readWord};
      s_axi_rresp <= (rSlot == 4'hf) ? 2'h2 : 2'h0;
    end
    else if (s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Events; a set in the same cycle as a write-one clear wins.
  // A calibration loss in the last count cycle must not report a lock.
  wire lockRise = lockOk && (lockState == LK_COUNT && lockCount == 16'h0001 ||
                  lockState == LK_WAIT && lockDelay == 16'h0000);
  wire modDone  = !dividerRelease && modCount == 32'h0000_0001;
  wire burstEnd = srState == SR_BURST && sysrefOut && srCount == 14'h0001 &&
                  pulseCount == burstCount;
  wire [`IRQ_BITS-1:0] events = {burstEnd, modDone, lockRise};
  wire [`IRQ_BITS-1:0] clearBits = (doWrite && wSlot == 4'ha && wStrb[0]) ?
                                   wData[`IRQ_BITS-1:0] : '0;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      auxControl <= 2'h0;
      irqMask <= '0;
      irqStatus <= '0;
      irq <= 1'b0;
    end
    else
    begin
      if (doWrite && wSlot == 4'h9 && wStrb[0])
        auxControl <= wData[1:0];
      if (doWrite && wSlot == 4'hb && wStrb[0])
        irqMask <= wData[`IRQ_BITS-1:0];
      irqStatus <= (irqStatus & ~clearBits) | events;
      irq <= |(((irqStatus & ~clearBits) | events) & irqMask);
    end
  end

  // Input pins are synchronised before use.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      syncMeta <= 2'h0;
      reqMeta <= 2'h0;
      reqPrev <= 1'b0;
    end
    else
    begin
      syncMeta <= {syncMeta[0], syncPin};
      reqMeta <= {reqMeta[0], sysrefRequestPin};
      reqPrev <= sysrefRequestActive;
    end
  end

  // [R01] pin gating
  wire pinsUsed = !pinDisregard && phaseSync;
  // [R05] format validity
  wire fmtBad = pinFormat[2];
  wire lvlBad = regs[0][`F_BIAS_HI:`F_BIAS_LO] == 2'h3;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      syncActive <= 1'b0;
      sysrefRequestActive <= 1'b0;
      highHysteresis <= 1'b0;
      biasLevel <= 2'h0;
      syncPinLvds <= 1'b0;
      requestPinLvds <= 1'b0;
      pinConfigInvalid <= 1'b0;
    end
    else
    begin
      syncActive <= pinsUsed && syncMeta[1];
      sysrefRequestActive <= pinsUsed && reqMeta[1];
      // [R02] LVDS hysteresis
      highHysteresis <= regs[0][`F_HIGH_HYST] && (pinFormat == 3'h1 || pinFormat == 3'h2 ||
                        pinFormat == 3'h3);
      // [R03] bias divider
      biasLevel <= regs[0][`F_BIAS_HI:`F_BIAS_LO];
      // [R05] pin formats
      syncPinLvds <= !fmtBad && pinFormat[0];
      requestPinLvds <= !fmtBad && pinFormat[1];
      pinConfigInvalid <= fmtBad || lvlBad;
    end
  end

  // [R07] delay count
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      lockState <= LK_WAIT;
      lockCount <= 16'h0000;
      lockDetect <= 1'b0;
    end
    else if (!lockOk)
    begin
      lockState <= LK_WAIT;
      lockDetect <= 1'b0;
    end
    else
    begin
      unique case (lockState)
        LK_WAIT:
        begin
          lockCount <= lockDelay;
          // [R08] zero delay
          lockState <= (lockDelay == 16'h0000) ? LK_LOCKED : LK_COUNT;
          lockDetect <= lockDelay == 16'h0000;
        end
        LK_COUNT:
        begin
          lockCount <= lockCount - 16'h0001;
          if (lockCount == 16'h0001)
          begin
            lockState <= LK_LOCKED;
            lockDetect <= 1'b1;
          end
        end
        LK_LOCKED:
          lockDetect <= 1'b1;
        default:
          lockState <= LK_WAIT;
      endcase
    end
  end

  // [R09] modulator wait
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      modCount <= 32'h0000_0000;
      dividerRelease <= 1'b1;
    end
    else if (modulatorReset && phaseSync && fractional && modWait != 32'h0000_0000)
    begin
      modCount <= modWait;
      dividerRelease <= 1'b0;
    end
    else if (!dividerRelease)
    begin
      modCount <= modCount - 32'h0000_0001;
      dividerRelease <= modCount == 32'h0000_0001;
    end
  end

  // [R12] prescaler decode
  wire preValid = prescaler == 3'h1 || prescaler == 3'h2 || prescaler == 3'h4;
  // [R15] divide by 4 plus 2 times code, half period scaled by prescaler
  wire [13:0] baseHalf = {3'h0, divCode} + 14'h0002;
  wire [13:0] halfPeriod = (prescaler == 3'h4) ? {baseHalf[11:0], 2'h0} :
                           (prescaler == 3'h2) ? {baseHalf[12:0], 1'b0} : baseHalf;
  wire burstTrigger = sysrefRequestActive && !reqPrev;
  // [R19] enable gates everything
  wire srRun = sysrefEnable && preValid;
  wire srHalfDone = srCount == 14'h0001;

  always_ff @(posedge ref_clk)
  begin
    if (rst || !srRun)
    begin
      srState <= SR_IDLE;
      srCount <= 14'h0000;
      sysrefOut <= 1'b0;
      pulseCount <= 4'h0;
    end
    else
    begin
      unique case (srState)
        SR_IDLE:
        begin
          srCount <= halfPeriod;
          pulseCount <= 4'h0;
          sysrefOut <= 1'b0;
          // [R14] master or repeater
          if (repeaterSel)
            srState <= SR_REPEAT;
          else if (!burstMode)
            srState <= SR_MASTER;
          // [R13] pulser start
          else if (burstTrigger && burstCount != 4'h0)
            srState <= SR_BURST;
        end
        SR_MASTER:
        begin
          if (repeaterSel || burstMode)
            srState <= SR_IDLE;
          srCount <= srHalfDone ? halfPeriod : srCount - 14'h0001;
          if (srHalfDone)
            sysrefOut <= !sysrefOut;
        end
        SR_BURST:
        begin
          srCount <= srHalfDone ? halfPeriod : srCount - 14'h0001;
          if (srHalfDone)
          begin
            sysrefOut <= !sysrefOut;
            if (!sysrefOut)
              pulseCount <= pulseCount + 4'h1;
            // [R17] burst length
            else if (pulseCount == burstCount)
              srState <= SR_IDLE;
          end
        end
        SR_REPEAT:
        begin
          sysrefOut <= sysrefRequestActive;
          if (!repeaterSel)
            srState <= SR_IDLE;
        end
      endcase
    end
  end

  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence lockSeen;
    $rose(lockOk) && lockState == LK_WAIT && lockDelay == 16'h0003;
  endsequence
  sequence heldOk3;
    lockOk [*4];
  endsequence

  pin_disregard_a: assert property (pinDisregard |=> !syncActive && !sysrefRequestActive) // [R01]
    else $error("Pins acted while disregarded.");
  hyst_cmos_a: assert property (pinFormat == 3'h0 |=> !highHysteresis) // [R02]
    else $error("High hysteresis on CMOS inputs.");
  bias_follow_a: assert property (##1 biasLevel == $past(regs[0][`F_BIAS_HI:`F_BIAS_LO])) // [R03]
    else $error("Bias level output wrong.");
  format_bad_a: assert property (fmtBad |=> pinConfigInvalid && !syncPinLvds) // [R05]
    else $error("Invalid format not flagged.");
  lock_source_a: assert property (lockSource && !vtuneOk |=> !lockDetect) // [R06]
    else $error("Lock without tuning monitor.");
  lock_delay_a: assert property ((lockSeen ##0 heldOk3) |=> lockDetect) // [R07]
    else $error("Lock detect not after delay.");
  lock_early_a: assert property (lockSeen |=> !lockDetect ##1 !lockDetect) // [R07]
    else $error("Lock detect too early.");
  lock_zero_a: assert property (lockOk && lockState == LK_WAIT && lockDelay == 16'h0000
    |=> lockDetect) // [R08]
    else $error("Zero delay lock not immediate.");
  mod_wait_a: assert property (modulatorReset && phaseSync && fractional &&
    modWait == 32'h0000_0005 |=> !dividerRelease [*5] ##1 dividerRelease) // [R09]
    else $error("Modulator wait length wrong.");
  pre_invalid_a: assert property (!preValid |=> srState == SR_IDLE && !sysrefOut) // [R12]
    else $error("Sysref ran with invalid prescaler.");
  repeat_follow_a: assert property (srState == SR_REPEAT && srRun && repeaterSel
    |=> sysrefOut == $past(sysrefRequestActive)) // [R14]
    else $error("Repeater output not following request.");
  master_half_a: assert property (srState == SR_MASTER && srRun && !burstMode && !repeaterSel
    && srHalfDone |=> sysrefOut != $past(sysrefOut)) // [R15]
    else $error("Master sysref did not toggle.");
  burst_bound_a: assert property (srState == SR_BURST |-> pulseCount <= burstCount) // [R17]
    else $error("Burst exceeded its count.");
  enable_off_a: assert property (!sysrefEnable |=> !sysrefOut && srState == SR_IDLE) // [R19]
    else $error("Sysref active while disabled.");
endmodule
`default_nettype wire

// [sim/sync_source_model.sv]
`timescale 1ns/100ps
`default_nettype none
module sync_source_model
(
  input  wire logic ref_clk,
  output var logic  syncPin,
  output var logic  sysrefRequestPin,
  output var logic  calibrationOk,
  output var logic  vtuneOk,
  output var logic  modulatorReset
);
  initial
  begin
    syncPin = 1'b0;
    sysrefRequestPin = 1'b0;
    calibrationOk = 1'b0;
    vtuneOk = 1'b0;
    modulatorReset = 1'b0;
  end
  task automatic setPins(input logic s, input logic r);
    @(posedge ref_clk);
    syncPin <= s;
    sysrefRequestPin <= r;
  endtask
  task automatic setCal(input logic c, input logic v);
    @(posedge ref_clk);
    calibrationOk <= c;
    vtuneOk <= v;
  endtask
  // The modulator reset is a single-cycle pulse; longer pulses would restart the wait.
  task automatic pulseMod();
    @(posedge ref_clk);
    modulatorReset <= 1'b1;
    @(posedge ref_clk);
    modulatorReset <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [sim/sync_sysref_lock_control_regs_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module sync_sysref_lock_control_regs_tb;
  import sync_regs_pkg::*;
  logic        ref_clk, rst, awv, wv, bry, arv, rry, awr, wrdy, bv, arr, rv;
  logic [11:0] awa, ara;
  logic [31:0] wd, rd, d;
  logic [1:0]  br, rr, resp, bias;
  wire logic   sPin, rPin, cal, vt, modR;
  logic        sAct, rAct, hyst, sL, rL, inv, lock, rel, sref, irq;
  int          errTotal, checksDone, cycles, n, h, r, v;
  logic [7:0]  idxTab [9] = '{8'h3a, 8'h3b, 8'h3c, 8'h45, 8'h46, 8'h47, 8'h48, 8'h49, 8'h4a};
  logic [15:0] rstTab [9] = '{16'h8001, 16'h0001, 16'h03e8, 16'h0000, 16'hc350, 16'h0081,
                              16'h0000, 16'h003f, 16'h0000};
  sync_sysref_lock_control_regs dut
  (
    .ref_clk(ref_clk), .rst(rst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wrdy), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .syncPin(sPin),
    .sysrefRequestPin(rPin), .calibrationOk(cal), .vtuneOk(vt), .modulatorReset(modR),
    .syncActive(sAct), .sysrefRequestActive(rAct), .highHysteresis(hyst), .biasLevel(bias),
    .syncPinLvds(sL), .requestPinLvds(rL), .pinConfigInvalid(inv), .lockDetect(lock),
    .dividerRelease(rel), .sysrefOut(sref), .irq(irq)
  );
  sync_source_model src
  (
    .ref_clk(ref_clk), .syncPin(sPin), .sysrefRequestPin(rPin), .calibrationOk(cal),
    .vtuneOk(vt), .modulatorReset(modR)
  );
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp)
    begin
      errTotal++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Handshakes are sampled in the settled half cycle, released right after the next edge.
  task automatic axi(input logic wr, input logic [7:0] idx, input logic [15:0] val);
    int k;
    logic aT, wT, done;
    k = 0;
    done = 1'b0;
    @(posedge ref_clk);
    awa <= {2'b00, idx, 2'b00};
    ara <= {2'b00, idx, 2'b00};
    wd <= {16'h0000, val};
    awv <= wr;
    wv <= wr;
    bry <= wr;
    arv <= !wr;
    rry <= !wr;
    while (!done && k < 200)
    begin
      @(negedge ref_clk);
      aT = (awv && awr) || (arv && arr);
      wT = wv && wrdy;
      done = wr ? bv : rv;
      d = rd;
      resp = wr ? br : rr;
      @(posedge ref_clk);
      if (aT)
      begin
        awv <= 1'b0;
        arv <= 1'b0;
      end
      if (wT)
        wv <= 1'b0;
      if (done)
      begin
        bry <= 1'b0;
        rry <= 1'b0;
      end
      k++;
    end
    check("busAnswer", {31'h0, done}, 32'h1);
  endtask
  task automatic wreg(input logic [7:0] idx, input logic [15:0] val);
    axi(1'b1, idx, val);
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [15:0] exp, input string what);
    axi(1'b0, idx, 16'h0000);
    check(what, d, {16'h0000, exp});
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
  endtask
  // Counts cycles with sysrefOut high (sel 0) or divider held (sel 1), and sysrefOut rises.
  task automatic watch(input int k, input logic sel, output int hi, output int ri);
    logic last;
    hi = 0;
    ri = 0;
    last = sref;
    repeat (k)
    begin
      @(negedge ref_clk);
      hi += sel ? int'(rel === 1'b0) : int'(sref === 1'b1);
      ri += int'(sref === 1'b1 && last === 1'b0);
      last = sref;
    end
  endtask
  task automatic halfHigh(output int hi);
    int g;
    g = 0;
    hi = 0;
    while (sref !== 1'b0 && g < 300)
    begin
      @(negedge ref_clk);
      g++;
    end
    while (sref !== 1'b1 && g < 600)
    begin
      @(negedge ref_clk);
      g++;
    end
    while (sref === 1'b1 && hi < 300)
    begin
      @(negedge ref_clk);
      hi++;
    end
  endtask
  function automatic logic [5:0] pinModel(input logic [15:0] p);
    logic sLv, rLv;
    sLv = (p[11:9] == 3'd1) || (p[11:9] == 3'd3);
    rLv = (p[11:9] == 3'd2) || (p[11:9] == 3'd3);
    return {p[14] && (sLv || rLv), p[13:12], sLv, rLv, (p[11:9] > 3'd3) || (p[13:12] == 2'd3)};
  endfunction
  task automatic tally_and_finish();
    if (errTotal == 0 && checksDone > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      errTotal++;
      tally_and_finish();
    end
  end
  initial
  begin
    rst = 1'b1;
    {awv, wv, bry, arv, rry} = 5'h00;
    awa = 12'h000;
    ara = 12'h000;
    wd = 32'h00000000;
    v = $urandom(21);
    cyc(6);
    rst <= 1'b0;
    foreach (idxTab[i])
      rdc(idxTab[i], rstTab[i], "resetValue");
    rdc(8'h20, 16'h0000, "unmapped");
    check("unmappedResp", {30'h0, resp}, 32'h2);
    wreg(8'h20, 16'h1234);
    check("unmappedWriteResp", {30'h0, resp}, 32'h2);
    for (int i = 0; i < 8; i++)
    begin
      v = $urandom;
      wreg(8'h3a, v[15:0]);
      rdc(8'h3a, (v[15:0] & 16'hfe00) | 16'h0001, "pinConfig");
      cyc(2);
      check("pinOutputs", {26'h0, hyst, bias, sL, rL, inv}, {26'h0, pinModel(v[15:0])});
    end
    wreg(8'h50, 16'h0001);
    wreg(8'h3a, 16'h1000);
    src.setPins(1'b1, 1'b1);
    cyc(6);
    check("pinsUsed", {30'h0, sAct, rAct}, 32'h3);
    wreg(8'h3a, 16'h9000);
    cyc(4);
    check("pinsIgnored", {30'h0, sAct, rAct}, 32'h0);
    src.setPins(1'b0, 1'b0);
    wreg(8'h3b, 16'h0000);
    wreg(8'h52, 16'h0001);
    for (int dl = 3; dl >= 0; dl -= 3)
    begin
      wreg(8'h3c, dl[15:0]);
      src.setCal(1'b1, 1'b0);
      n = 0;
      do
      begin
        @(negedge ref_clk);
        n++;
      end while (lock !== 1'b1 && n < 50);
      check("lockDelay", n, dl + 2);
      cyc(1);
      check("irqRaised", {31'h0, irq}, 32'h1);
      src.setCal(1'b0, 1'b0);
      wreg(8'h51, 16'h0001);
      check("irqCleared", {31'h0, irq}, 32'h0);
    end
    wreg(8'h3b, 16'h0001);
    src.setCal(1'b1, 1'b0);
    cyc(8);
    check("lockNeedsTune", {31'h0, lock}, 32'h0);
    src.setCal(1'b1, 1'b1);
    cyc(3);
    check("lockWithTune", {31'h0, lock}, 32'h1);
    wreg(8'h50, 16'h0003);
    // wait set small for the run
    wreg(8'h46, 16'h0005);
    src.pulseMod();
    watch(20, 1'b1, h, r);
    check("modWait", h, 5);
    wreg(8'h50, 16'h0001);
    src.pulseMod();
    watch(20, 1'b1, h, r);
    check("modWaitInteger", h, 0);
    for (int i = 0; i < 3; i++)
    begin
      v = (i == 0) ? 1 : 2 * i;
      wreg(8'h48, (i == 0) ? 16'h0000 : 16'h0001);
      wreg(8'h47, 16'h0008 | v[2:0] << 5); // enable set whenever sysref is used
      halfHigh(h);
      check("sysrefHalf", h, v * ((i == 0) ? 2 : 3));
    end
    wreg(8'h47, 16'h0020);
    watch(40, 1'b0, h, r);
    check("sysrefOff", h, 0);
    wreg(8'h47, 16'h0068);
    watch(40, 1'b0, h, r);
    check("prescalerInvalid", h, 0);
    wreg(8'h4a, 16'h3000);
    wreg(8'h48, 16'h0000);
    wreg(8'h3a, 16'h1000);
    wreg(8'h47, 16'h0038);
    src.setPins(1'b0, 1'b1);
    watch(150, 1'b0, h, r);
    check("burstPulses", r, 3);
    wreg(8'h47, 16'h002c);
    src.setPins(1'b0, 1'b0);
    cyc(6);
    src.setPins(1'b0, 1'b1);
    cyc(6);
    check("repeatHigh", {31'h0, sref}, 32'h1);
    src.setPins(1'b0, 1'b0);
    cyc(6);
    check("repeatLow", {31'h0, sref}, 32'h0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
